// File: inc/wnac_pkg.sv
// Shared constants, state codes and helpers for the wiper and memory block
package wnac_pkg;
  // Clock and timing
  localparam int CLK_MHZ       = 125;
  localparam int NV_WC_TIME_MS = 6;
  localparam int NV_WC_CYCLES  = NV_WC_TIME_MS * CLK_MHZ * 1000;
  localparam logic [4:0] BOOT_CYCLES = 5'h10;

  // Geometry
  localparam int ADDR_W     = 11;
  localparam int DATA_W     = 8;
  localparam int WIPER_W    = 7;
  localparam int PAGE_BYTES = 16;
  localparam int PAGES      = 128;
  localparam int MEM_BYTES  = PAGE_BYTES * PAGES;

  // Memory map
  localparam logic [10:0] ADDR_GP_LAST    = 11'h7fb;
  localparam logic [10:0] ADDR_RSVD_A     = 11'h7fc;
  localparam logic [10:0] ADDR_RSVD_B     = 11'h7fd;
  localparam logic [10:0] ADDR_ACCESS_CTL = 11'h7fe;
  localparam logic [10:0] ADDR_WIPER_IVR  = 11'h7ff;

  // Reset values and fields
  localparam logic [6:0] WIPER_RESET = 7'h40;
  localparam logic       OV_RESET    = 1'b0;
  localparam int         OV_BIT      = 7;
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam logic [2:0] BIT_LAST    = 3'h7;

  // Link state machine
  typedef enum logic [10:0] {
    ST_BOOT     = 11'h001,
    ST_IDLE     = 11'h002,
    ST_ID       = 11'h004,
    ST_ACK_ID   = 11'h008,
    ST_ADDR     = 11'h010,
    ST_ACK_ADDR = 11'h020,
    ST_WDATA    = 11'h040,
    ST_ACK_W    = 11'h080,
    ST_RDATA    = 11'h100,
    ST_RACK     = 11'h200,
    ST_NVWR     = 11'h400
  } wnac_state_t;

  // Next address inside the same page
  function automatic logic [10:0] wnac_page_inc(input logic [10:0] a);
    wnac_page_inc = {a[10:4], 4'(a[3:0] + 4'h1)};
  endfunction : wnac_page_inc
endpackage : wnac_pkg

// File: inc/wnac_if.sv
// Internal carriers: line events and memory port
`timescale 1ns/1ns
interface wnac_pin_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;
  logic wp_n;
  modport src (output scl_rise, scl_fall, start, stop, sda, wp_n);
  modport dst (input scl_rise, scl_fall, start, stop, sda, wp_n);
endinterface : wnac_pin_if

interface wnac_mem_if;
  logic        wr_en;
  logic [10:0] wr_addr;
  logic [7:0]  wr_data;
  logic        commit;
  logic        busy;
  logic        pending;
  logic [10:0] rd_addr;
  logic [7:0]  rd_data;
  modport ctl (output wr_en, wr_addr, wr_data, commit, rd_addr,
               input busy, pending, rd_data);
  modport mem (input wr_en, wr_addr, wr_data, commit, rd_addr,
               output busy, pending, rd_data);
endinterface : wnac_mem_if

// File: logic/wnac_pin_sync.sv
// Pin synchronisers with clock edge, start and stop detection
`timescale 1ns/1ns
module wnac_pin_sync
  import wnac_pkg::*;
(
  input wire logic clk,       // System clock
  input wire logic rst_n,     // Async reset, active low
  input wire logic scl_pin,   // Serial clock pin
  input wire logic sda_pin,   // Serial data pin level
  input wire logic wp_pin_n,  // Write protect pin, active low
  wnac_pin_if.src  ev         // Detected line events
);
  logic [2:0] scl_reg, scl_next;
  logic [2:0] sda_reg, sda_next;
  logic [1:0] wp_reg,  wp_next;

  // Shift stages: [0] meta, [1] stable, [2] delayed copy
  always_comb
  begin
    scl_next = {scl_reg[1:0], scl_pin};
    sda_next = {sda_reg[1:0], sda_pin};
    wp_next  = {wp_reg[0], wp_pin_n};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_reg <= 3'h7;
      sda_reg <= 3'h7;
      wp_reg  <= 2'h3;
    end
    else
    begin
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      wp_reg  <= wp_next;
    end
  end

  // Events from stable stages only
  assign ev.scl_rise = scl_reg[1] & ~scl_reg[2];
  assign ev.scl_fall = ~scl_reg[1] & scl_reg[2];
  assign ev.start    = scl_reg[1] & scl_reg[2] & ~sda_reg[1] & sda_reg[2];
  assign ev.stop     = scl_reg[1] & scl_reg[2] & sda_reg[1] & ~sda_reg[2];
  assign ev.sda      = sda_reg[1];
  assign ev.wp_n     = wp_reg[1];

  property p_start_needs_high_scl;
    @(posedge clk) disable iff (!rst_n)
      ev.start |-> (ev.scl_rise == 1'b0) && !ev.stop && $past(ev.sda);
  endproperty
  a_start_needs_high_scl : assert property (p_start_needs_high_scl)
    else $error("start seen without high clock");
endmodule : wnac_pin_sync

// File: logic/wnac_nv_store.sv
// Non-volatile byte array with page buffer and self-timed write cycle
`timescale 1ns/1ns
module wnac_nv_store
  import wnac_pkg::*;
#(
  parameter int WC_CYCLES = NV_WC_CYCLES  // Write cycle length in clocks
)
(
  input wire logic clk,    // System clock
  input wire logic rst_n,  // Async reset, active low
  wnac_mem_if.mem  m       // Access port
);
  localparam int CW = $clog2(WC_CYCLES + 1);

  logic [7:0]    mem_reg [0:MEM_BYTES-1];
  logic [7:0]    buf_reg [0:PAGE_BYTES-1];
  logic [7:0]    buf_next [0:PAGE_BYTES-1];
  logic [15:0]   vld_reg, vld_next;
  logic [6:0]    page_reg, page_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic          busy_reg, busy_next;
  logic          done;

  // Page load, launch and countdown
  always_comb
  begin
    buf_next  = buf_reg;
    vld_next  = vld_reg;
    page_next = page_reg;
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    done      = 1'b0;
    if (busy_reg)
    begin
      if (cnt_reg == '0)
      begin
        busy_next = 1'b0;
        done      = 1'b1;
        vld_next  = 16'h0000;
      end
      else
        cnt_next = CW'(cnt_reg - 1'b1);
    end
    else if (m.commit && (vld_reg != 16'h0000))
    begin
      busy_next = 1'b1;
      cnt_next  = CW'(WC_CYCLES - 1);
    end
    else if (m.wr_en)
    begin
      buf_next[m.wr_addr[3:0]] = m.wr_data;
      vld_next[m.wr_addr[3:0]] = 1'b1;
      page_next                = m.wr_addr[10:4];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
        buf_reg[i] <= 8'h00;
      vld_reg  <= 16'h0000;
      page_reg <= 7'h00;
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end
    else
    begin
      buf_reg  <= buf_next;
      vld_reg  <= vld_next;
      page_reg <= page_next;
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  // Array keeps its contents through reset; all loaded bytes of the page land at once
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < PAGE_BYTES; i++)
      if (done && vld_reg[i])
        mem_reg[{page_reg, 4'(i)}] <= buf_reg[i];
  end

  assign m.busy    = busy_reg;
  assign m.pending = vld_reg != 16'h0000;
  assign m.rd_data = mem_reg[m.rd_addr];

  property p_wc_length;
    @(posedge clk) disable iff (!rst_n)
      $rose(busy_reg) |-> (cnt_reg == CW'(WC_CYCLES - 1));
  endproperty
  a_wc_length : assert property (p_wc_length)
    else $error("write cycle started with wrong length");
endmodule : wnac_nv_store

// File: logic/wnac_top.sv
// Wiper and non-volatile memory access over the two-wire link
`timescale 1ns/1ns
// Function
// - Seven-bit volatile wiper register drives the tap select output.
// - Code zero sits at the low terminal, all ones at the high.
// - Wiper is forced to midscale 0x40 while powering up.
// - After power-up the stored initial value is copied into the wiper.
// - Store holds 2048 bytes as 128 pages of 16, one cycle per page.
// - Eleven-bit byte address covers 0x000 to 0x7ff.
// - Bytes 0x000 to 0x7fb are plain storage, no wiper effect.
// - Top bit of 0x7fe is the volatile-only flag, zero at power-up.
// - Reading 0x7ff gives wiper if flag set, stored value otherwise.
// - Writing 0x7ff sets wiper only, or wiper and stored value.
// - Control and wiper bytes may come in one or two writes.
// - First byte: 1010, three high address bits, direction bit.
// - Stop after stored bytes launches a write cycle; volatile-only idles.
// - Written data bytes go to rising addresses, kept within one page; read bytes run on across pages.
// - Write protect low: drop data byte, no acknowledge, back to idle.
module wnac_top
  import wnac_pkg::*;
#(
  parameter int NV_WC_CYCLES_P = NV_WC_CYCLES  // Write cycle length in clocks
)
(
  input  wire logic       clk,                 // 125 MHz clock
  input  wire logic       rst_n,               // Async power-up reset
  input  wire logic       scl_line,            // Serial clock pin
  input  wire logic       sda_line,            // Serial data pin level
  output logic            sda_drive,           // Data drive value, always low
  output logic            sda_oe_n,            // Low while pulling data low
  input  wire logic       wp_n,                // Write protect, active low
  output logic [6:0]      wiper_pot_register,  // Tap select
  output logic            volatile_only_flag,  // Access control flag
  output logic            nv_busy              // Write cycle running
);
  wnac_pin_if ev ();
  wnac_mem_if m ();

  wnac_state_t state_reg, state_next;
  logic [7:0]  shift_reg, shift_next;
  logic [7:0]  tx_reg,    tx_next;
  logic [2:0]  bit_reg,   bit_next;
  logic        rdy_reg,   rdy_next;
  logic [10:0] ptr_reg,   ptr_next;
  logic        rw_reg,    rw_next;
  logic [6:0]  wiper_reg, wiper_next;
  logic        ov_reg,    ov_next;
  logic        oe_n_reg,  oe_n_next;
  logic [4:0]  boot_reg,  boot_next;
  logic [7:0]  byte_in;
  logic        byte_done;
  logic        load_tx;
  logic        linked;

  wnac_pin_sync u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .scl_pin  (scl_line),
    .sda_pin  (sda_line),
    .wp_pin_n (wp_n),
    .ev     (ev)
  );

  wnac_nv_store #(.WC_CYCLES(NV_WC_CYCLES_P)) u_store (
    .clk   (clk),
    .rst_n (rst_n),
    .m     (m)
  );

  // Byte seen at the top of the map, upper bit forced low for 0x7ff and carrying the flag for 0x7fe
  function automatic logic [7:0] wnac_read_byte(
    input logic [10:0] a,
    input logic [7:0]  stored,
    input logic [6:0]  wiper,
    input logic        ov
  );
    if (a == ADDR_WIPER_IVR)
      wnac_read_byte = ov ? {1'b0, wiper} : {1'b0, stored[6:0]};
    else if (a == ADDR_ACCESS_CTL)
      wnac_read_byte = {ov, 7'h00};
    else
      wnac_read_byte = stored;
  endfunction : wnac_read_byte

  // Shared helpers
  assign byte_in   = {shift_reg[6:0], ev.sda};
  assign byte_done = ev.scl_fall && rdy_reg;
  assign linked    = (state_reg != ST_BOOT) && (state_reg != ST_NVWR);
  assign m.rd_addr = (state_reg == ST_BOOT) ? ADDR_WIPER_IVR : ptr_reg;

  // Link sequencer and register effects
  always_comb
  begin
    state_next = state_reg;
    shift_next = shift_reg;
    tx_next    = tx_reg;
    bit_next   = bit_reg;
    rdy_next   = rdy_reg;
    ptr_next   = ptr_reg;
    rw_next    = rw_reg;
    wiper_next = wiper_reg;
    ov_next    = ov_reg;
    oe_n_next  = oe_n_reg;
    boot_next  = boot_reg;
    m.wr_en    = 1'b0;
    m.wr_addr  = ptr_reg;
    m.wr_data  = shift_reg;
    m.commit   = 1'b0;
    load_tx    = 1'b0;
    // Receive shifting on rising clock in byte states
    if ((state_reg == ST_ID || state_reg == ST_ADDR || state_reg == ST_WDATA)
        && ev.scl_rise)
    begin
      shift_next = byte_in;
      bit_next   = 3'(bit_reg + 3'h1);
      rdy_next   = bit_reg == BIT_LAST;
    end
    unique case (state_reg)
      ST_BOOT:
      begin
        if (boot_reg == 5'h00)
        begin
          wiper_next = m.rd_data[6:0];
          state_next = ST_IDLE;
        end
        else
          boot_next = 5'(boot_reg - 5'h01);
      end
      ST_IDLE: ;
      ST_ID:
      begin
        if (byte_done)
        begin
          rdy_next = 1'b0;
          if (shift_reg[7:4] == DEV_TYPE_CODE)
          begin
            ptr_next[10:8] = shift_reg[3:1];
            rw_next        = shift_reg[0];
            oe_n_next      = 1'b0;
            state_next     = ST_ACK_ID;
          end
          else
            state_next = ST_IDLE;
        end
      end
      ST_ACK_ID:
      begin
        if (ev.scl_fall)
        begin
          bit_next = 3'h0;
          if (rw_reg)
          begin
            load_tx    = 1'b1;
            tx_next    = wnac_read_byte(ptr_reg, m.rd_data, wiper_reg, ov_reg);
            oe_n_next  = tx_next[7];
            state_next = ST_RDATA;
          end
          else
          begin
            oe_n_next  = 1'b1;
            state_next = ST_ADDR;
          end
        end
      end
      ST_ADDR:
      begin
        if (byte_done)
        begin
          rdy_next      = 1'b0;
          ptr_next[7:0] = shift_reg;
          oe_n_next     = 1'b0;
          state_next    = ST_ACK_ADDR;
        end
      end
      ST_ACK_ADDR, ST_ACK_W:
      begin
        if (ev.scl_fall)
        begin
          oe_n_next  = 1'b1;
          bit_next   = 3'h0;
          state_next = ST_WDATA;
        end
      end
      ST_WDATA:
      begin
        if (byte_done)
        begin
          rdy_next = 1'b0;
          if (!ev.wp_n)
            state_next = ST_IDLE;
          else
          begin
            if (ptr_reg == ADDR_ACCESS_CTL)
              ov_next = shift_reg[OV_BIT];
            else if (ptr_reg == ADDR_WIPER_IVR)
            begin
              wiper_next = shift_reg[6:0];
              m.wr_en    = !ov_reg;
            end
            else
              m.wr_en = 1'b1;
            ptr_next   = wnac_page_inc(ptr_reg);
            oe_n_next  = 1'b0;
            state_next = ST_ACK_W;
          end
        end
      end
      ST_RDATA:
      begin
        if (ev.scl_fall)
        begin
          if (bit_reg == BIT_LAST)
          begin
            oe_n_next  = 1'b1;
            ptr_next   = 11'(ptr_reg + 11'h001);
            state_next = ST_RACK;
          end
          else
          begin
            tx_next   = {tx_reg[6:0], 1'b0};
            oe_n_next = tx_reg[6];
            bit_next  = 3'(bit_reg + 3'h1);
          end
        end
      end
      ST_RACK:
      begin
        if (ev.scl_rise)
        begin
          if (ev.sda)
            state_next = ST_IDLE;
          else
            rdy_next = 1'b1;
        end
        else if (byte_done)
        begin
          rdy_next   = 1'b0;
          bit_next   = 3'h0;
          load_tx    = 1'b1;
          tx_next    = wnac_read_byte(ptr_reg, m.rd_data, wiper_reg, ov_reg);
          oe_n_next  = tx_next[7];
          state_next = ST_RDATA;
        end
      end
      ST_NVWR:
      begin
        if (!m.busy)
          state_next = ST_IDLE;
      end
    endcase
    // Start and stop override; both ignored at boot and during a write cycle
    if (linked && ev.start)
    begin
      state_next = ST_ID;
      bit_next   = 3'h0;
      rdy_next   = 1'b0;
      oe_n_next  = 1'b1;
    end
    else if (linked && ev.stop)
    begin
      rdy_next   = 1'b0;
      oe_n_next  = 1'b1;
      m.commit   = m.pending;
      state_next = m.pending ? ST_NVWR : ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_BOOT;
      shift_reg <= 8'h00;
      tx_reg    <= 8'h00;
      bit_reg   <= 3'h0;
      rdy_reg   <= 1'b0;
      ptr_reg   <= 11'h000;
      rw_reg    <= 1'b0;
      wiper_reg <= WIPER_RESET;
      ov_reg    <= OV_RESET;
      oe_n_reg  <= 1'b1;
      boot_reg  <= BOOT_CYCLES;
    end
    else
    begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      tx_reg    <= tx_next;
      bit_reg   <= bit_next;
      rdy_reg   <= rdy_next;
      ptr_reg   <= ptr_next;
      rw_reg    <= rw_next;
      wiper_reg <= wiper_next;
      ov_reg    <= ov_next;
      oe_n_reg  <= oe_n_next;
      boot_reg  <= boot_next;
    end
  end

  // Outputs; tap order follows the code directly
  assign sda_drive          = 1'b0;
  assign sda_oe_n           = oe_n_reg;
  assign wiper_pot_register = wiper_reg;
  assign volatile_only_flag = ov_reg;
  assign nv_busy            = m.busy;

  // Checks
  property p_boot_mid;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_BOOT) |-> (wiper_reg == WIPER_RESET) && !ov_reg;
  endproperty
  a_boot_mid : assert property (p_boot_mid)
    else $error("wiper not at midscale during boot");

  property p_boot_load;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_BOOT && boot_reg == 5'h00)
        |=> (wiper_reg == $past(m.rd_data[6:0])) && (state_reg == ST_IDLE);
  endproperty
  a_boot_load : assert property (p_boot_load)
    else $error("stored wiper value not loaded");

  property p_top_read;
    @(posedge clk) disable iff (!rst_n)
      (load_tx && ptr_reg == ADDR_WIPER_IVR) |=> !tx_reg[7] &&
        (tx_reg[6:0] == ($past(ov_reg) ? $past(wiper_reg) : $past(m.rd_data[6:0])));
  endproperty
  a_top_read : assert property (p_top_read)
    else $error("wrong source for top byte read");

  property p_top_write;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_WDATA && byte_done && ev.wp_n && ptr_reg == ADDR_WIPER_IVR)
        |-> (m.wr_en == !ov_reg) ##1 (wiper_reg == $past(shift_reg[6:0]));
  endproperty
  a_top_write : assert property (p_top_write)
    else $error("top byte write went to wrong place");

  property p_gp_no_side;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_WDATA && byte_done && ev.wp_n && ptr_reg <= ADDR_GP_LAST)
        |-> m.wr_en ##1 ($stable(wiper_reg) && $stable(ov_reg));
  endproperty
  a_gp_no_side : assert property (p_gp_no_side)
    else $error("plain byte write touched the wiper");

  property p_wp_drop;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_WDATA && byte_done && !ev.wp_n)
        |-> !m.wr_en ##1 (state_reg == ST_IDLE && oe_n_reg && $stable(wiper_reg));
  endproperty
  a_wp_drop : assert property (p_wp_drop)
    else $error("protected write was accepted");

  sequence s_stop_pending;
    linked && ev.stop && m.pending;
  endsequence
  sequence s_cycle_runs;
    (state_reg == ST_NVWR && m.busy) [*2];
  endsequence
  property p_nv_launch;
    @(posedge clk) disable iff (!rst_n)
      s_stop_pending |=> s_cycle_runs;
  endproperty
  a_nv_launch : assert property (p_nv_launch)
    else $error("stop did not launch write cycle");

  property p_volatile_stop;
    @(posedge clk) disable iff (!rst_n)
      (linked && ev.stop && !m.pending && !ev.start) |=> state_reg == ST_IDLE;
  endproperty
  a_volatile_stop : assert property (p_volatile_stop)
    else $error("volatile-only write did not idle");

  property p_page_inc;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_WDATA && byte_done && ev.wp_n && !ev.start && !ev.stop)
        |=> (ptr_reg[10:4] == $past(ptr_reg[10:4]))
            && (ptr_reg[3:0] == 4'($past(ptr_reg[3:0]) + 4'h1));
  endproperty
  a_page_inc : assert property (p_page_inc)
    else $error("write address left its page");

  property p_bad_id;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_ID && byte_done && shift_reg[7:4] != DEV_TYPE_CODE
        && !ev.start && !ev.stop) |=> (state_reg == ST_IDLE) && oe_n_reg;
  endproperty
  a_bad_id : assert property (p_bad_id)
    else $error("foreign identification byte acknowledged");
endmodule : wnac_top

// File: dv/wnac_master_model.sv
// Two-wire bus master model for the serial link
`timescale 1ns/1ns
module wnac_master_model
(
  input  wire logic clk,      // Bench clock
  output logic      scl,      // Serial clock, parked high
  output logic      sda_low,  // Pulls data low when set
  input  wire logic sda_line  // Resolved data wire
);
  // Idle bus: clock high, data released to pull-up
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  // One clock of 160 ns; data moves mid low phase
  task automatic bit_x(input logic b, output logic r);
    scl <= 1'b0;
    hold(5);
    sda_low <= ~b;
    hold(5);
    scl <= 1'b1;
    hold(10);
    r = sda_line;
  endtask : bit_x

  // Start or repeated start: data falls while clock high
  task automatic start();
    scl <= 1'b0;
    hold(5);
    sda_low <= 1'b0;
    hold(5);
    scl <= 1'b1;
    hold(10);
    sda_low <= 1'b1;
    hold(10);
  endtask : start

  // Stop: data rises while clock high, clock stays high
  task automatic stop();
    scl <= 1'b0;
    hold(5);
    sda_low <= 1'b1;
    hold(5);
    scl <= 1'b1;
    hold(10);
    sda_low <= 1'b0;
    hold(10);
  endtask : stop

  // Byte out, MSB first, then sample the slave answer
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  // Byte in, MSB first; answer held off on the last byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask : rd_byte
endmodule : wnac_master_model

// File: dv/wnac_top_tb.sv
// Self-checking bench for the wiper and memory access block
`timescale 1ns/1ns
module wnac_top_tb;
  import wnac_pkg::*;
  localparam int NVWC = 200;
  logic       clk, rst_n, wp_n, scl, m_low, sda_w;
  logic       sda_drive, sda_oe_n, volatile_only_flag, nv_busy;
  logic [6:0] wiper_pot_register;
  int         errors, cmp_count, cyc;

  // Open-drain data wire with pull-up
  assign sda_w = ~(m_low | (~sda_oe_n & ~sda_drive));

  wnac_top #(.NV_WC_CYCLES_P(NVWC)) uut (.clk(clk), .rst_n(rst_n), .scl_line(scl),
    .sda_line(sda_w), .sda_drive(sda_drive), .sda_oe_n(sda_oe_n), .wp_n(wp_n),
    .wiper_pot_register(wiper_pot_register), .volatile_only_flag(volatile_only_flag),
    .nv_busy(nv_busy));
  wnac_master_model m (.clk(clk), .scl(scl), .sda_low(m_low), .sda_line(sda_w));

  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic chk(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk

  // Write one or two bytes from address a
  task automatic wr(input logic [10:0] a, input logic [7:0] d0, d1, input int n,
                    output logic ok);
    logic k;
    m.start();
    m.wr_byte({4'ha, a[10:8], 1'b0}, k);
    ok = k;
    m.wr_byte(a[7:0], k);
    ok &= k;
    m.wr_byte(d0, k);
    ok &= k;
    if (n > 1)
    begin
      m.wr_byte(d1, k);
      ok &= k;
    end
    m.stop();
  endtask : wr

  // Random read: address phase, repeated start, one or two bytes
  task automatic rd(input logic [10:0] a, input int n, output logic [7:0] r0, r1);
    logic k;
    m.start();
    m.wr_byte({4'ha, a[10:8], 1'b0}, k);
    m.wr_byte(a[7:0], k);
    m.start();
    m.wr_byte({4'ha, a[10:8], 1'b1}, k);
    m.rd_byte(n == 1, r0);
    if (n > 1)
      m.rd_byte(1'b1, r1);
    m.stop();
  endtask : rd

  // Wait out the write cycle, bounded
  task automatic settle();
    int n;
    n = 0;
    while (nv_busy !== 1'b0 && n < NVWC + 50)
    begin
      @(posedge clk);
      n++;
    end
    chk(nv_busy === 1'b0, "write cycle hung");
    m.hold(20);
  endtask : settle

  task automatic t_power();
    logic ok;
    logic [7:0] r0, r1;
    wr(11'h7ff, 8'h25, 8'h00, 1, ok);
    chk(ok === 1'b1 && wiper_pot_register === 7'h25, "wiper write");
    chk(nv_busy === 1'b1, "write cycle not launched");
    settle();
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk(wiper_pot_register === 7'h40, "midscale in reset");
    chk(volatile_only_flag === 1'b0, "flag in reset");
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge clk);
    chk(wiper_pot_register === 7'h25, "power-up load");
    rd(11'h7ff, 1, r0, r1);
    chk(r0 === 8'h25, "stored read");
    $display("test power done");
  endtask : t_power

  task automatic t_volatile();
    logic ok;
    logic [7:0] r0, r1;
    wr(11'h7fe, 8'h80, 8'h33, 2, ok);
    chk(ok === 1'b1 && volatile_only_flag === 1'b1, "flag set");
    chk(wiper_pot_register === 7'h33, "volatile wiper");
    chk(nv_busy === 1'b0, "volatile write launched cycle");
    rd(11'h7fe, 2, r0, r1);
    chk(r0 === 8'h80 && r1 === 8'h33, "control and wiper read");
    wr(11'h7fe, 8'h00, 8'h00, 1, ok);
    rd(11'h7ff, 1, r0, r1);
    chk(r0 === 8'h25, "store untouched");
    wr(11'h7ff, 8'h7f, 8'h00, 1, ok);
    chk(wiper_pot_register === 7'h7f, "top code");
    settle();
    rd(11'h7ff, 1, r0, r1);
    chk(r0 === 8'h7f, "store top code");
    $display("test volatile done");
  endtask : t_volatile

  task automatic t_general();
    logic ok;
    logic [7:0] r0, r1;
    wr(11'h120, 8'ha5, 8'h5a, 2, ok);
    chk(ok === 1'b1 && nv_busy === 1'b1, "page write");
    settle();
    rd(11'h120, 2, r0, r1);
    chk(r0 === 8'ha5 && r1 === 8'h5a, "page read");
    wr(11'h7fb, 8'h3c, 8'h00, 1, ok);
    settle();
    rd(11'h7fb, 1, r0, r1);
    chk(r0 === 8'h3c, "last plain byte");
    chk(wiper_pot_register === 7'h7f, "wiper disturbed");
    $display("test general done");
  endtask : t_general

  task automatic t_refuse();
    logic ok;
    logic [7:0] r0, r1;
    wp_n <= 1'b0;
    wr(11'h120, 8'h00, 8'h00, 1, ok);
    chk(ok === 1'b0 && nv_busy === 1'b0, "protected write taken");
    wp_n <= 1'b1;
    m.hold(20);
    rd(11'h120, 1, r0, r1);
    chk(r0 === 8'ha5, "protected byte changed");
    m.start();
    m.wr_byte(8'h90, ok);
    m.stop();
    chk(ok === 1'b0, "foreign id answered");
    $display("test refuse done");
  endtask : t_refuse

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial
  begin
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    rst_n = 1'b0;
    wp_n = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge clk);
    t_power();
    t_volatile();
    t_general();
    t_refuse();
    tally_and_finish();
  end
endmodule : wnac_top_tb
